/* File: rtl/ddrcap_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ddrcap_top (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic forwarded_sample_clock_i,
    input wire logic [15:0] ab_sample_bus_i,
    input wire logic [15:0] cd_sample_bus_i,
    input wire logic frame_strobe_input_i,
    input wire logic frame_strobe_mirror_i,
    input wire logic bus_reverse_i,
    input wire logic interface_reverse_i,
    input wire ddrcap_pkg::ddrcap_strb_mode_t strobe_mode_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output ddrcap_pkg::ddrcap_word_t out_word_o,
    output logic fifo_sync_o,
    output logic sync_source_o,
    output logic parity_error_o,
    output logic overflow_o
);
    import ddrcap_pkg::*;

    // First and second synchroniser stages for all pins
    ddrcap_pins_t pin_meta, next_pin_meta;
    ddrcap_pins_t pin_sync, next_pin_sync;
    // Last seen forwarded clock level, for edge finding
    logic clk_prev, next_clk_prev;
    // Registered capture word and its strobe
    ddrcap_word_t cap_word, next_cap_word;
    logic cap_valid, next_cap_valid;
    // Strobe role pulses and sticky overflow
    logic fifo_sync, next_fifo_sync;
    logic sync_src, next_sync_src;
    logic parity_err, next_parity_err;
    logic overflow, next_overflow;
    // Edge and selection terms
    logic rise_now, fall_now;
    logic [15:0] ab_pick, cd_pick, ab_ord, cd_ord;
    logic strb_pick, rev_order, fifo_in_ready;

    // Synchroniser shift; clock and data share the same delay so they stay aligned
    always_comb begin
        next_pin_meta.clk = forwarded_sample_clock_i;
        next_pin_meta.ab = ab_sample_bus_i;
        next_pin_meta.cd = cd_sample_bus_i;
        next_pin_meta.strobe = frame_strobe_input_i;
        next_pin_meta.strobe_alt = frame_strobe_mirror_i;
        next_pin_sync = pin_meta;
        next_clk_prev = pin_sync.clk;
    end

    // Synchroniser registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_meta <= DDRCAP_PINS_RST;
            pin_sync <= DDRCAP_PINS_RST;
            clk_prev <= DDRCAP_FLAG_RST;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
            clk_prev <= next_clk_prev;
        end
    end

    // Both edges of the forwarded clock are found here
    assign rise_now = pin_sync.clk && !clk_prev;
    assign fall_now = !pin_sync.clk && clk_prev;

    // Lane selection: a mirrored interface swaps the buses and the strobe pin
    always_comb begin
        ab_pick = interface_reverse_i ? pin_sync.cd : pin_sync.ab;
        cd_pick = interface_reverse_i ? pin_sync.ab : pin_sync.cd;
        strb_pick = interface_reverse_i ? pin_sync.strobe_alt : pin_sync.strobe;
        // A full mirror also flips bit order, so either bit does it
        rev_order = bus_reverse_i || interface_reverse_i;
        ab_ord = rev_order ? ddrcap_bitrev(ab_pick) : ab_pick;
        cd_ord = rev_order ? ddrcap_bitrev(cd_pick) : cd_pick;
    end

    // Capture on every edge; strobe taken only on the rising one
    always_comb begin
        next_cap_valid = rise_now || fall_now;
        next_cap_word = cap_word;
        if (rise_now || fall_now) begin
            next_cap_word.ab = ab_ord;
            next_cap_word.cd = cd_ord;
            next_cap_word.strobe = rise_now && strb_pick;
            next_cap_word.rise = rise_now;
        end
        // Strobe roles, each a one-cycle pulse on a rising edge
        next_fifo_sync = rise_now && strb_pick && (strobe_mode_i == DDRCAP_STRB_FIFO_SYNC);
        next_sync_src = rise_now && strb_pick && (strobe_mode_i == DDRCAP_STRB_SYNC_SRC);
        // Even parity over the AB word plus the parity bit
        next_parity_err = rise_now && (strobe_mode_i == DDRCAP_STRB_PARITY)
                          && ((^ab_ord) != strb_pick);
        // The source cannot be stalled, so a refused word is lost and flagged
        next_overflow = overflow || (cap_valid && !fifo_in_ready);
    end

    // Capture registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cap_word <= DDRCAP_WORD_RST;
            cap_valid <= DDRCAP_FLAG_RST;
            fifo_sync <= DDRCAP_FLAG_RST;
            sync_src <= DDRCAP_FLAG_RST;
            parity_err <= DDRCAP_FLAG_RST;
            overflow <= DDRCAP_FLAG_RST;
        end else begin
            cap_word <= next_cap_word;
            cap_valid <= next_cap_valid;
            fifo_sync <= next_fifo_sync;
            sync_src <= next_sync_src;
            parity_err <= next_parity_err;
            overflow <= next_overflow;
        end
    end

    // Role pulses and the overflow flag leave straight from their flops
    assign fifo_sync_o = fifo_sync;
    assign sync_source_o = sync_src;
    assign parity_error_o = parity_err;
    assign overflow_o = overflow;

    // Elastic store between capture and the consumer
    ddrcap_fifo #(
        .WIDTH(DDRCAP_WORD_W),
        .DEPTH(DDRCAP_FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .in_valid_i(cap_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(cap_word),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o(out_word_o)
    );

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    // Rising edge of the synchronised clock
    sequence s_rise;
        pin_sync.clk && !clk_prev;
    endsequence

    // Falling edge of the synchronised clock
    sequence s_fall;
        !pin_sync.clk && clk_prev;
    endsequence

    // Every rising edge yields a word marked as the first of its pair
    property p_rise_capture;
        s_rise |=> cap_valid && cap_word.rise;
    endproperty
    a_rise_capture: assert property (p_rise_capture) else $error("rising edge not captured");

    // Every falling edge yields the second word of the pair
    property p_fall_capture;
        s_fall |=> cap_valid && !cap_word.rise;
    endproperty
    a_fall_capture: assert property (p_fall_capture) else $error("falling edge not captured");

    // A falling-edge word carries no strobe and fires no strobe role in its own cycle
    property p_strobe_rise_only;
        cap_valid && !cap_word.rise |-> !cap_word.strobe && !fifo_sync && !sync_src
                                        && !parity_err;
    endproperty
    a_strobe_rise_only: assert property (p_strobe_rise_only) else $error("strobe on fall");

    // With no reordering both lanes pass through unchanged
    property p_plain_order;
        (s_rise or s_fall) ##0 (!bus_reverse_i && !interface_reverse_i)
        |=> cap_word.ab == $past(pin_sync.ab) && cap_word.cd == $past(pin_sync.cd);
    endproperty
    a_plain_order: assert property (p_plain_order) else $error("bus order wrong");

    // Bus reverse alone flips bit order but keeps the lanes in place
    property p_bus_reverse;
        (s_rise or s_fall) ##0 (bus_reverse_i && !interface_reverse_i)
        |=> cap_word.ab == ddrcap_bitrev($past(pin_sync.ab));
    endproperty
    a_bus_reverse: assert property (p_bus_reverse) else $error("bus not reversed");

    // A mirrored interface swaps lanes, flips bits and reads the mirror strobe pin
    property p_iface_mirror;
        s_rise ##0 interface_reverse_i
        |=> cap_word.cd == ddrcap_bitrev($past(pin_sync.ab))
            && cap_word.strobe == $past(pin_sync.strobe_alt);
    endproperty
    a_iface_mirror: assert property (p_iface_mirror) else $error("interface not mirrored");

    // Pointer sync is a single-cycle pulse, never a level
    property p_fifo_sync_pulse;
        s_rise ##0 (pin_sync.strobe && !interface_reverse_i
                    && strobe_mode_i == DDRCAP_STRB_FIFO_SYNC)
        |=> fifo_sync ##1 !fifo_sync;
    endproperty
    a_fifo_sync_pulse: assert property (p_fifo_sync_pulse) else $error("no fifo sync");

    // Odd weight over the word and its parity bit must be reported
    property p_parity_check;
        s_rise ##0 (strobe_mode_i == DDRCAP_STRB_PARITY && !interface_reverse_i
                    && !bus_reverse_i && ((^pin_sync.ab) != pin_sync.strobe))
        |=> parity_err;
    endproperty
    a_parity_check: assert property (p_parity_check) else $error("parity miss");

    // A capture word only ever follows a seen clock edge
    property p_valid_has_cause;
        cap_valid |-> $past(pin_sync.clk) != $past(clk_prev);
    endproperty
    a_valid_has_cause: assert property (p_valid_has_cause) else $error("spurious capture");

    // A word the buffer refuses is flagged, and the flag holds until reset;
    // the source cannot be paused, so losing a word silently would go unseen
    property p_overflow_sticky;
        overflow || (cap_valid && !fifo_in_ready) |=> overflow;
    endproperty
    a_overflow_sticky: assert property (p_overflow_sticky) else $error("lost word not flagged");

endmodule
`default_nettype wire

/* File: rtl/ddrcap_pkg.sv */
// What this block does
// - Accept 16-bit CD bus, bit 15 MSB
// - Accept 16-bit AB bus, same clocking
// - Bus-reverse bit flips sample bit order
// - Capture both buses on both clock edges
// - Strobe syncs FIFO, gives sync, or parity
// - Strobe sampled only on rising clock edge
// - Interface-reverse mirrors strobe path and buses
`default_nettype none
package ddrcap_pkg;

    // Width of each sample bus
    localparam int unsigned DDRCAP_BUS_W = 16;
    // Depth of the capture FIFO
    localparam int unsigned DDRCAP_FIFO_DEPTH = 4;
    // Synchroniser length for every pin input
    localparam int unsigned DDRCAP_SYNC_STAGES = 2;

    // Role given to the strobe pin
    typedef enum logic [1:0] {
        DDRCAP_STRB_FIFO_SYNC,
        DDRCAP_STRB_SYNC_SRC,
        DDRCAP_STRB_PARITY
    } ddrcap_strb_mode_t;

    // One captured DDR word as it enters the FIFO
    typedef struct packed {
        logic [15:0] ab;
        logic [15:0] cd;
        logic strobe;
        logic rise;
    } ddrcap_word_t;

    // Raw pin levels, grouped for the synchroniser
    typedef struct packed {
        logic clk;
        logic [15:0] ab;
        logic [15:0] cd;
        logic strobe;
        logic strobe_alt;
    } ddrcap_pins_t;

    localparam int unsigned DDRCAP_WORD_W = $bits(ddrcap_word_t);
    // Values after reset
    localparam ddrcap_word_t DDRCAP_WORD_RST = '0;
    localparam ddrcap_pins_t DDRCAP_PINS_RST = '0;
    localparam logic DDRCAP_FLAG_RST = 1'b0;

    // Mirror a sample word end for end
    function automatic logic [15:0] ddrcap_bitrev(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

endpackage
`default_nettype wire

/* File: rtl/ddrcap_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module ddrcap_fifo #(
    parameter int unsigned WIDTH = 34,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

    // Storage words
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, next_wr_ptr;
    logic [PW-1:0] rd_ptr, next_rd_ptr;
    // Fill level, one bit wider than the pointers
    logic [PW:0] count, next_count;
    logic push, pop;

    // Honest flags straight from the fill level
    assign in_ready_o = (count != DEPTH_C);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and level update; wrap by compare since depth need not be a power of two
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Pointer registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // A full FIFO never takes a word
    property p_no_push_full;
        @(posedge clock_i) disable iff (!rstn_i)
        (count == DEPTH_C) |=> (count == DEPTH_C) || $past(pop);
    endproperty
    a_no_push_full: assert property (p_no_push_full) else $error("fifo grew past depth");

endmodule
`default_nettype wire

/* File: dv/ddrcap_src_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Upstream sample source: forwarded clock at 80 ns, stands still low between pairs
module ddrcap_src_model (
    input wire logic clock_i,
    input wire logic interface_reverse_i,
    output logic fclk_o,
    output logic [15:0] ab_o,
    output logic [15:0] cd_o,
    output logic strobe_o,
    output logic strobe_mirror_o
);
    // Idle levels at time zero
    initial begin
        fclk_o = 1'b0;
        ab_o = 16'h0000;
        cd_o = 16'h0000;
        strobe_o = 1'b0;
        strobe_mirror_o = 1'b1;
    end

    // Strobe goes to the pin the current orientation reads; the other pin shows the inverse
    task automatic put(input logic [15:0] ab, input logic [15:0] cd, input logic s);
        ab_o = ab;
        cd_o = cd;
        strobe_o = interface_reverse_i ? ~s : s;
        strobe_mirror_o = interface_reverse_i ? s : ~s;
    endtask

    // One rise/fall pair; strobe and data change together with the clock
    task automatic send_pair(input logic [15:0] ab_r, input logic [15:0] cd_r, input logic s_r,
                             input logic [15:0] ab_f, input logic [15:0] cd_f, input logic s_f);
        @(negedge clock_i);
        #0.7;
        put(ab_r, cd_r, s_r);
        fclk_o = 1'b1;
        #40;
        put(ab_f, cd_f, s_f);
        fclk_o = 1'b0;
        #40;
        // Hold time over: show the inverse so stale values are never mistaken for data
        put(~ab_f, ~cd_f, ~s_f);
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_ddr_lvds_sample_input_capture.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_ddr_lvds_sample_input_capture;
    import ddrcap_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic fclk, strobe, mirror, bus_rev = 1'b0, if_rev = 1'b0, out_ready = 1'b1;
    logic [15:0] ab, cd;
    ddrcap_strb_mode_t mode = DDRCAP_STRB_FIFO_SYNC;
    logic out_valid, fifo_sync, sync_src, par_err, overflow;
    ddrcap_word_t out_word;
    ddrcap_word_t got[$], exp[$];
    int num_errors = 0, check_count = 0, cycles = 0, n_fs = 0, n_ss = 0, n_pe = 0;

    always #2 clock_i = ~clock_i;

    ddrcap_src_model u_src (.clock_i(clock_i), .interface_reverse_i(if_rev), .fclk_o(fclk),
        .ab_o(ab), .cd_o(cd), .strobe_o(strobe), .strobe_mirror_o(mirror));

    ddrcap_top u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .forwarded_sample_clock_i(fclk),
        .ab_sample_bus_i(ab), .cd_sample_bus_i(cd), .frame_strobe_input_i(strobe),
        .frame_strobe_mirror_i(mirror), .bus_reverse_i(bus_rev), .interface_reverse_i(if_rev),
        .strobe_mode_i(mode), .out_valid_o(out_valid), .out_ready_i(out_ready),
        .out_word_o(out_word), .fifo_sync_o(fifo_sync), .sync_source_o(sync_src),
        .parity_error_o(par_err), .overflow_o(overflow));

    // Collect popped words at the edge that pops them
    always @(posedge clock_i) begin
        if (rstn_i && out_valid === 1'b1 && out_ready) got.push_back(out_word);
    end

    // Count the one-cycle pulses mid-cycle, where they are settled; an unknown counts
    always @(negedge clock_i) begin
        n_fs += (fifo_sync !== 1'b0);
        n_ss += (sync_src !== 1'b0);
        n_pe += (par_err !== 1'b0);
    end

    // Hang guard: the whole run needs a few hundred cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [15:0] rv(input logic [15:0] v);
        logic [15:0] r;
        r = {<<{v}};
        return r;
    endfunction

    // Expected lane value after the configured reordering
    function automatic logic [15:0] pick(input logic [15:0] mine, input logic [15:0] other);
        if (if_rev) return rv(other);
        return bus_rev ? rv(mine) : mine;
    endfunction

    // Send one pair and queue the two words it should become
    task automatic pair(input logic [15:0] ar, input logic [15:0] cr, input logic sr,
                        input logic [15:0] af, input logic [15:0] cf, input logic sf);
        exp.push_back('{ab: pick(ar, cr), cd: pick(cr, ar), strobe: sr, rise: 1'b1});
        exp.push_back('{ab: pick(af, cf), cd: pick(cf, af), strobe: 1'b0, rise: 1'b0});
        u_src.send_pair(ar, cr, sr, af, cf, sf);
    endtask

    // Wait for every queued word, then compare field by field
    task automatic drain();
        for (int i = 0; i < 300 && got.size() < exp.size(); i++) @(posedge clock_i);
        `CHK(got.size(), exp.size())
        for (int i = 0; i < exp.size() && i < got.size(); i++) begin
            `CHK(got[i].ab, exp[i].ab)
            `CHK(got[i].cd, exp[i].cd)
            `CHK(got[i].rise, exp[i].rise)
            `CHK(got[i].strobe, exp[i].strobe)
        end
        got.delete();
        exp.delete();
    endtask

    // Plain order, then a strobe high only on the falling edge must not count
    task automatic t_plain();
        n_fs = 0;
        pair(16'h8001, 16'h1234, 1'b1, 16'hFFFE, 16'h0001, 1'b0);
        pair(16'h00FF, 16'hA5C3, 1'b0, 16'h7F00, 16'h8000, 1'b1);
        drain();
        `CHK(n_fs, 1)
    endtask

    // Bit order reversal of both buses
    task automatic t_bus_rev();
        @(negedge clock_i) bus_rev = 1'b1;
        pair(16'h8001, 16'h0003, 1'b0, 16'h1200, 16'hC000, 1'b0);
        drain();
        @(negedge clock_i) bus_rev = 1'b0;
    endtask

    // Whole interface mirrored: lanes swapped, bits reversed, strobe from mirror pin
    task automatic t_if_rev();
        @(negedge clock_i) begin
            if_rev = 1'b1;
            mode = DDRCAP_STRB_SYNC_SRC;
        end
        n_ss = 0;
        pair(16'h0001, 16'hF000, 1'b1, 16'h8421, 16'h0F0F, 1'b0);
        drain();
        `CHK(n_ss, 1)
        @(negedge clock_i) if_rev = 1'b0;
    endtask

    // Every strobe role, with odd parity so the parity role flags it
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            @(negedge clock_i) mode = ddrcap_strb_mode_t'(m);
            n_fs = 0;
            n_ss = 0;
            n_pe = 0;
            pair(16'h0003, 16'h5555, 1'b1, 16'h0000, 16'h0000, 1'b0);
            `CHK(n_fs, int'(m == 0))
            `CHK(n_ss, int'(m == 1))
            `CHK(n_pe, int'(m == 2))
        end
        // Even parity over the AB word and strobe raises nothing
        @(negedge clock_i) mode = DDRCAP_STRB_PARITY;
        n_pe = 0;
        pair(16'h0007, 16'h0000, 1'b1, 16'h0000, 16'h0000, 1'b0);
        `CHK(n_pe, 0)
        drain();
    endtask

    // Stall the consumer until the four-word buffer refuses, then drain it
    task automatic t_overflow();
        `CHK(overflow, 1'b0)
        @(negedge clock_i) out_ready = 1'b0;
        pair(16'h1111, 16'h2222, 1'b0, 16'h3333, 16'h4444, 1'b0);
        pair(16'h5555, 16'h6666, 1'b0, 16'h7777, 16'h8888, 1'b0);
        pair(16'h9999, 16'hAAAA, 1'b0, 16'hBBBB, 16'hCCCC, 1'b0);
        void'(exp.pop_back());
        void'(exp.pop_back());
        `CHK(out_valid, 1'b1)
        `CHK(overflow, 1'b1)
        @(negedge clock_i) out_ready = 1'b1;
        drain();
        repeat (2) @(negedge clock_i);
        `CHK(out_valid, 1'b0)
    endtask

    initial begin
        repeat (5) @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (5) @(negedge clock_i);
        t_plain();
        t_bus_rev();
        t_if_rev();
        t_modes();
        t_overflow();
        finish_test();
    end
endmodule
`default_nettype wire
